// *** include/bod_seq_if.sv ***
// Purpose: Carrier between register logic and the brown-out unlock sequencer
// Assumes: One clock domain
// Notes:   wr is a one-cycle write strobe of power_control_reg
interface bod_seq_if;
	logic wr;
	logic wr_off;
	logic wr_unlock;
	logic off_bit;
	logic unlock_bit;
	logic effective;
	modport seq  (input wr, wr_off, wr_unlock, output off_bit, unlock_bit, effective);
	modport ctrl (output wr, wr_off, wr_unlock, input off_bit, unlock_bit, effective);
endinterface

// *** include/pwr_pkg.sv ***
// Purpose: Shared constants and types for sleep and clock gating control
// Assumes: 8-bit register port, registers at byte offsets
// Notes:   Cycle counts are at the system clock rate
package pwr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int GATE_W = 4;
	localparam int CNT_W  = 3;
	// Register offsets
	localparam logic [ADDR_W-1:0] GATE_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h01;
	// Field positions of power_control_reg
	localparam int CTRL_OFF_BIT    = 7;
	localparam int CTRL_SE_BIT     = 5;
	localparam int CTRL_SM_HI      = 4;
	localparam int CTRL_SM_LO      = 3;
	localparam int CTRL_UNLOCK_BIT = 2;
	// Field positions of peripheral_gate_reg
	localparam int GATE_T1_BIT   = 3;
	localparam int GATE_T0_BIT   = 2;
	localparam int GATE_SER_BIT  = 1;
	localparam int GATE_CONV_BIT = 0;
	// Gate bits whose peripheral runs on the converter clock
	localparam logic [GATE_W-1:0] GATE_ON_ADC = 4'h1;
	// Reset values
	localparam logic [GATE_W-1:0] GATE_RST  = 4'h0;
	localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
	// Timed unlock sequence, in clock cycles
	localparam logic [CNT_W-1:0] UNLOCK_WIN_CYC = 3'h4;
	localparam logic [CNT_W-1:0] OFF_DELAY_CYC  = 3'h3;
	localparam logic [CNT_W-1:0] OFF_HOLD_CYC   = 3'h3;
	localparam logic [CNT_W-1:0] OFF_SPAN_CYC   = OFF_DELAY_CYC + OFF_HOLD_CYC;
	typedef enum logic [1:0] {
		MODE_IDLE    = 2'h0,
		MODE_NOISE   = 2'h1,
		MODE_PDOWN   = 2'h2,
		MODE_STANDBY = 2'h3
	} sleep_mode_t;
	typedef enum logic [1:0] {
		ST_RUN   = 2'h1,
		ST_SLEEP = 2'h2
	} pwr_state_t;
endpackage

// *** testbench/sleep_clock_ctrl_chk.sv ***
// Purpose: Port-level assertions for sleep and clock gating control
// Assumes: One clock, synchronous active-high reset
// Notes:   Tracks sleep enable and mode from register writes
module sleep_clock_ctrl_chk #(
	parameter int NPIN      = 8,
	parameter bit SW_OFF_EN = 1'b1
) (
	input wire logic                 mclk_i,
	input wire logic                 sys_rst_i,
	input wire logic [7:0]           reg_addr_i,
	input wire logic [7:0]           reg_wdata_i,
	input wire logic                 reg_wr_i,
	input wire logic                 reg_rd_i,
	input wire logic [7:0]           reg_rdata_o,
	input wire logic                 sleep_instr_i,
	input wire logic                 wdt_en_i,
	input wire logic                 conv_en_i,
	input wire logic                 conv_start_i,
	input wire logic                 bod_fuse_en_i,
	input wire logic [NPIN-1:0]      wake_pin_mask_i,
	input wire logic                 sleeping_o,
	input wire pwr_pkg::sleep_mode_t sleep_mode_o,
	input wire logic                 cpu_clk_en_o,
	input wire logic                 adc_clk_en_o,
	input wire logic                 osc_en_o,
	input wire logic                 timer1_clk_en_o,
	input wire logic                 timer0_clk_en_o,
	input wire logic                 serial_clk_en_o,
	input wire logic                 conv_clk_en_o,
	input wire logic                 conv_extended_o,
	input wire logic                 comp_en_o,
	input wire logic [NPIN-1:0]      in_buf_en_o,
	input wire logic                 bod_en_o,
	input wire logic                 wdt_en_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import pwr_pkg::*;
	logic       se_q;
	logic [1:0] sm_q;
	logic [1:0] up_q;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Shadow of sleep enable and mode, and cycles since reset
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			se_q <= 1'b0;
			sm_q <= 2'h0;
			up_q <= 2'h0;
		end
		else
		begin
			up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
			if (reg_wr_i && reg_addr_i == CTRL_ADDR)
			begin
				se_q <= reg_wdata_i[CTRL_SE_BIT];
				sm_q <= reg_wdata_i[CTRL_SM_HI:CTRL_SM_LO];
			end
		end
	end
	chk_gate_hi_zero: assert property (
		reg_rd_i && reg_addr_i == GATE_ADDR |=> reg_rdata_o[7:4] == 4'h0) else $error("gate hi");
	chk_unmapped_read: assert property (
		reg_rd_i && reg_addr_i > CTRL_ADDR |=> reg_rdata_o == 8'h00) else $error("unmapped");
	chk_sleep_refused: assert property (
		sleep_instr_i && !sleeping_o && !se_q |=> !sleeping_o) else $error("slept");
	chk_sleep_entry: assert property (
		sleep_instr_i && !sleeping_o && se_q |=> sleeping_o && !cpu_clk_en_o
		&& sleep_mode_o == $past(sm_q)) else $error("entry");
	chk_deep_osc: assert property (
		sleeping_o && sleep_mode_o[1] |-> !adc_clk_en_o && osc_en_o == sleep_mode_o[0])
		else $error("deep clocks");
	chk_t1_stop: assert property (
		reg_wr_i && reg_addr_i == GATE_ADDR && reg_wdata_i[GATE_T1_BIT] |=> !timer1_clk_en_o)
		else $error("t1");
	chk_t0_stop: assert property (
		reg_wr_i && reg_addr_i == GATE_ADDR && reg_wdata_i[GATE_T0_BIT] |=> !timer0_clk_en_o)
		else $error("t0");
	chk_gate_resume: assert property (
		reg_wr_i && reg_addr_i == GATE_ADDR && reg_wdata_i == 8'h00 && !sleeping_o
		&& !sleep_instr_i |=> timer1_clk_en_o && timer0_clk_en_o && serial_clk_en_o)
		else $error("resume");
	chk_conv_stop: assert property (
		reg_wr_i && reg_addr_i == GATE_ADDR && reg_wdata_i[GATE_CONV_BIT]
		|=> !conv_clk_en_o ##1 !comp_en_o) else $error("conv stop");
	chk_inbuf_mask: assert property (
		sleeping_o && $past(sleeping_o) && sleep_mode_o[1] && $stable(wake_pin_mask_i)
		|-> in_buf_en_o == wake_pin_mask_i) else $error("inbuf");
	chk_bod_awake: assert property (
		up_q == 2'h3 && !sleeping_o && !$past(sleeping_o) |-> bod_en_o == $past(bod_fuse_en_i))
		else $error("bod");
	chk_wdt_kept: assert property (
		up_q == 2'h3 |-> wdt_en_o == $past(wdt_en_i)) else $error("wdt");
	chk_ext_rise: assert property (
		up_q == 2'h3 && $rose(conv_en_i) |=> conv_extended_o) else $error("ext set");
	chk_ext_clear: assert property (
		up_q == 2'h3 && conv_start_i && !$rose(conv_en_i) |=> !conv_extended_o)
		else $error("ext clr");
	chk_unlock_read: assert property (
		SW_OFF_EN && reg_wr_i && reg_addr_i == CTRL_ADDR && reg_wdata_i[7] && reg_wdata_i[2]
		##1 !reg_wr_i ##1 reg_rd_i && reg_addr_i == CTRL_ADDR |=> reg_rdata_o[CTRL_UNLOCK_BIT])
		else $error("unlock");
endmodule // sleep_clock_ctrl_chk

bind sleep_clock_ctrl sleep_clock_ctrl_chk #(.NPIN(NPIN), .SW_OFF_EN(SW_OFF_EN)) u_chk (.*);

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for sleep and clock gating control
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Random gate values from a fixed seed beside corner cases
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import pwr_pkg::*;
	logic        mclk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  addr = 8'h00, wdat = 8'h00, mask = 8'h00, rdat, ibuf, v, p, d;
	logic        wr = 1'b0, rd = 1'b0, slp = 1'b0, wake = 1'b0, fuse = 1'b1, wdt = 1'b0;
	logic        cen = 1'b0, cst = 1'b0, cmp = 1'b1, cref = 1'b0, e;
	logic        sleeping, cpu, io, adc, osc, t1, t0, ser, cv, reinit, cen_o, ext, cmp_o;
	logic        bod, wdt_o;
	sleep_mode_t mode;
	int          err_total = 0, tests_run = 0, cyc = 0;
	int          gap [7] = '{1, 2, 4, 5, 2, 2, 2};
	// Standby is entered with the crystal clock assumed selected
	logic [1:0]  smd [7] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h0, 2'h2};
	sleep_clock_ctrl u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
		.sleep_instr_i(slp), .wake_i(wake), .bod_fuse_en_i(fuse), .wdt_en_i(wdt),
		.conv_en_i(cen), .conv_start_i(cst), .comp_en_i(cmp), .comp_uses_ref_i(cref),
		.wake_pin_mask_i(mask), .sleeping_o(sleeping), .sleep_mode_o(mode),
		.cpu_clk_en_o(cpu), .io_clk_en_o(io), .adc_clk_en_o(adc), .osc_en_o(osc),
		.timer1_clk_en_o(t1), .timer0_clk_en_o(t0), .serial_clk_en_o(ser),
		.conv_clk_en_o(cv), .serial_reinit_o(reinit), .conv_en_o(cen_o),
		.conv_extended_o(ext), .comp_en_o(cmp_o), .in_buf_en_o(ibuf), .bod_en_o(bod),
		.wdt_en_o(wdt_o));
	// Clock and hang guard
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			summarize();
		end
	end
	// Expected {io, adc, osc} enables while asleep in mode m
	function automatic logic [2:0] exp_en(input logic [1:0] m);
		return {m == 2'h0, !m[1], m != 2'h2};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] x);
		@(posedge mclk_i);
		wr <= 1'b1;
		addr <= a;
		wdat <= x;
		@(posedge mclk_i);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [7:0] x);
		@(posedge mclk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk_i);
		rd <= 1'b0;
		#1 x = rdat;
	endtask
	// One-cycle sleep instruction or wake event
	task automatic ev(input logic w);
		@(posedge mclk_i);
		wake <= w;
		slp <= !w;
		@(posedge mclk_i);
		wake <= 1'b0;
		slp <= 1'b0;
		#1;
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		void'($urandom(73044));
		repeat (5) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		rreg(GATE_ADDR, d);
		chk(d, 8'h00);
		rreg(CTRL_ADDR, d);
		chk(d, 8'h00);
		wreg(8'h02, 8'hff);
		rreg(8'h02, d);
		chk(d, 8'h00);
		p = 8'h00;
		for (int i = 0; i < 24; i++)
		begin
			v = (i < 16) ? (8'(i) | 8'hf0) : 8'($urandom);
			wreg(GATE_ADDR, v); // Converter kept disabled before its stop bit
			chk({3'h0, reinit, t1, t0, ser, cv}, {3'h0, p[1] & ~v[1], ~v[3:0]});
			rreg(GATE_ADDR, d);
			chk(d, {4'h0, v[3:0]});
			chk({7'h0, cmp_o}, {7'h0, ~v[0]});
			p = v;
		end
		wreg(GATE_ADDR, 8'h00);
		// Converter re-enable, with a start in the same cycle once
		for (int k = 0; k < 2; k++)
		begin
			@(posedge mclk_i);
			cen <= 1'b0;
			@(posedge mclk_i);
			cen <= 1'b1;
			cst <= 1'(k);
			@(posedge mclk_i);
			cst <= 1'b0;
			#1 chk({6'h0, ext, cen_o}, 8'h03);
		end
		@(posedge mclk_i);
		cst <= 1'b1;
		@(posedge mclk_i);
		cst <= 1'b0;
		#1 chk({7'h0, ext}, 8'h00);
		// Every sleep mode, refused and taken
		for (int m = 0; m < 4; m++)
		begin
			@(posedge mclk_i);
			mask <= 8'($urandom);
			fuse <= 1'($urandom);
			wdt <= 1'($urandom);
			cref <= 1'($urandom);
			wreg(CTRL_ADDR, {3'h0, 2'(m), 3'h0});
			ev(1'b0);
			chk({7'h0, sleeping}, 8'h00);
			wreg(CTRL_ADDR, {3'h1, 2'(m), 3'h0});
			ev(1'b0);
			@(posedge mclk_i);
			#1 chk({sleeping, mode, cpu, io, adc, osc, 1'b0}, {1'b1, 2'(m), 1'b0, exp_en(2'(m)), 1'b0});
			chk(ibuf, m[1] ? mask : 8'hff);
			chk({4'h0, cmp_o, bod, wdt_o, cen_o}, {4'h0, !m[1] | cref, fuse, wdt, 1'b1});
			ev(1'b1);
			chk({7'h0, sleeping}, 8'h00);
		end
		fuse <= 1'b1;
		// Timed unlock: read-back, arming at the last window cycle, self-clear
		wreg(CTRL_ADDR, 8'h84);
		rreg(CTRL_ADDR, d);
		chk(d & 8'h04, 8'h04);
		wreg(CTRL_ADDR, 8'h80);
		rreg(CTRL_ADDR, d);
		chk(d & 8'h80, 8'h80);
		rreg(CTRL_ADDR, d);
		chk(d, 8'h00);
		// Sleep at varying distance from arming; last entry arms too late
		for (int j = 0; j < 7; j++)
		begin
			wreg(CTRL_ADDR, {3'h5, smd[j], 3'h4});
			if (j == 6)
				repeat (3) @(posedge mclk_i);
			wreg(CTRL_ADDR, {3'h5, smd[j], 3'h0});
			repeat (gap[j]) @(posedge mclk_i);
			ev(1'b0);
			e = (j != 6) && smd[j][1] && gap[j] inside {[2:4]};
			chk({7'h0, bod}, {7'h0, !e});
			ev(1'b1);
			@(posedge mclk_i);
			#1 chk({7'h0, bod}, 8'h01);
		end
		summarize();
	end
endmodule // testbench

// *** verilog/bod_sleep_seq.sv ***
// Purpose: Timed unlock sequence for the brown-out sleep-off bit
// Assumes: Writes arrive as one-cycle strobes on the carrier
// Notes:   Off bit reads one for three cycles, then is effective three cycles
module bod_sleep_seq #(
	parameter bit SW_OFF_EN = 1'b1
) (
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	bod_seq_if.seq    bus
);
	import pwr_pkg::*;

	typedef struct packed {
		logic             unlock;
		logic [CNT_W-1:0] win;
		logic [CNT_W-1:0] age;
		logic             off;
		logic             eff;
	} seq_state_t;

	seq_state_t q;
	seq_state_t d;

	// Next state of the unlock window and the off-bit lifetime
	always_comb
	begin
		d = q;
		if (q.win != '0)
		begin
			d.win = q.win - 3'h1;
		end
		if (q.age != '0)
		begin
			d.age = q.age - 3'h1;
		end
		if (bus.wr)
		begin
			if (bus.wr_off && bus.wr_unlock)
			begin
				d.unlock = 1'b1;
				d.win    = UNLOCK_WIN_CYC;
			end
			else if (bus.wr_off && q.unlock && q.win != '0)
			begin
				d.unlock = 1'b0;
				d.win    = '0;
				d.age    = OFF_SPAN_CYC;
			end
			else
			begin
				// Late off write leaves the off lifetime running; plain write clears it
				d.unlock = bus.wr_unlock;
				d.win    = '0;
				if (!bus.wr_off)
				begin
					d.age = '0;
				end
			end
		end
		if (d.win == '0)
		begin
			d.unlock = 1'b0;                // Window closed
		end
		d.off = d.age > OFF_HOLD_CYC;
		d.eff = d.age != '0 && d.age <= OFF_HOLD_CYC;
		if (!SW_OFF_EN)
		begin
			d = '0;
		end
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	// Outputs straight from the state
	assign bus.off_bit    = q.off;
	assign bus.unlock_bit = q.unlock;
	assign bus.effective  = q.eff;
endmodule // bod_sleep_seq

// *** verilog/sleep_clock_ctrl.sv ***
// Purpose: Sleep entry, sleep modes and per-peripheral clock gating
// Assumes: Register port strobes are one cycle, read data one cycle later
// Notes:   Clock outputs are enables for gates outside this block
// Behaviour
// - The off bit takes effect three cycles after the sequence sets it.
// - The off bit clears itself three cycles after being set.
// - Detector goes off only if sleep executes while off is effective.
// - Without software disable, the off bit is unused and reads zero.
// - Without software disable, the unlock bit is unused and reads zero.
// - Sleep instruction sleeps only when sleep_enable is one.
// - Mode select: 00 idle, 01 noise reduction, 10 power-down, 11 standby.
// - The unlock bit permits setting the off bit through the sequence.
// - Gate register bits 7:4 always read zero.
// - Timer 1 stop bit freezes timer 1; clearing resumes it.
// - Timer 0 stop bit freezes timer 0; clearing resumes it.
// - Serial stop bit stops its clock; software reinitialises it after.
// - Comparator unavailable while the converter stop bit is set.
// - Converter stays enabled in sleep; re-enable makes next conversion long.
// - Comparator off in power-down and standby unless using the reference.
// - Input buffers off when io and converter clocks stop, except wake pins.
// - A fuse-enabled brown-out detector stays on in all sleep modes unless software disable is effective in power-down or standby.
// - An enabled watchdog stays enabled in all sleep modes.
// - A software-disabled detector comes back on at wake-up.
// - Software disable works only in deep modes; zero is the default.
module sleep_clock_ctrl #(
	parameter int NPIN      = 8,
	parameter bit SW_OFF_EN = 1'b1
) (
	input  wire logic                         mclk_i,
	input  wire logic                         sys_rst_i,
	input  wire logic [pwr_pkg::ADDR_W-1:0]   reg_addr_i,
	input  wire logic [pwr_pkg::DATA_W-1:0]   reg_wdata_i,
	input  wire logic                         reg_wr_i,
	input  wire logic                         reg_rd_i,
	output logic      [pwr_pkg::DATA_W-1:0]   reg_rdata_o,
	input  wire logic                         sleep_instr_i,
	input  wire logic                         wake_i,
	input  wire logic                         bod_fuse_en_i,
	input  wire logic                         wdt_en_i,
	input  wire logic                         conv_en_i,
	input  wire logic                         conv_start_i,
	input  wire logic                         comp_en_i,
	input  wire logic                         comp_uses_ref_i,
	input  wire logic [NPIN-1:0]              wake_pin_mask_i,
	output logic                              sleeping_o,
	output pwr_pkg::sleep_mode_t              sleep_mode_o,
	output logic                              cpu_clk_en_o,
	output logic                              io_clk_en_o,
	output logic                              adc_clk_en_o,
	output logic                              osc_en_o,
	output logic                              timer1_clk_en_o,
	output logic                              timer0_clk_en_o,
	output logic                              serial_clk_en_o,
	output logic                              conv_clk_en_o,
	output logic                              serial_reinit_o,
	output logic                              conv_en_o,
	output logic                              conv_extended_o,
	output logic                              comp_en_o,
	output logic      [NPIN-1:0]              in_buf_en_o,
	output logic                              bod_en_o,
	output logic                              wdt_en_o
);
	import pwr_pkg::*;

	typedef struct packed {
		pwr_state_t        st;
		sleep_mode_t       mode;
		sleep_mode_t       sm_sel;
		logic              se;
		logic [GATE_W-1:0] gate;
		logic [DATA_W-1:0] rdata;
		logic              bod_off;
		logic              conv_prev;
		logic              conv_ext;
		logic              cpu_en;
		logic              io_en;
		logic              adc_en;
		logic              osc_en;
		logic [GATE_W-1:0] per_en;
		logic              ser_reinit;
		logic              conv_en;
		logic              comp_en;
		logic [NPIN-1:0]   buf_en;
		logic              bod_en;
		logic              wdt_en;
	} ctrl_state_t;

	ctrl_state_t q;
	ctrl_state_t d;
	bod_seq_if   seq_bus ();

	logic ctrl_wr;
	logic gate_wr;
	logic deep_sel;
	logic deep_now;
	logic gate_run;

	// The sleep-off request is judged only at sleep entry; a mode write made
	// while asleep cannot switch the detector off afterwards.

	// Write decode of the two registers
	assign ctrl_wr = reg_wr_i && reg_addr_i == CTRL_ADDR;
	assign gate_wr = reg_wr_i && reg_addr_i == GATE_ADDR;

	// Off and unlock writes go to the sequencer
	assign seq_bus.wr        = ctrl_wr;
	assign seq_bus.wr_off    = reg_wdata_i[CTRL_OFF_BIT];
	assign seq_bus.wr_unlock = reg_wdata_i[CTRL_UNLOCK_BIT];

	// Timed unlock sequence for the brown-out sleep-off bit
	bod_sleep_seq #(
		.SW_OFF_EN (SW_OFF_EN)
	) u_bod_seq (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.bus       (seq_bus.seq)
	);

	// Selected mode is power-down or standby, where the io and converter clocks stop
	assign deep_sel = q.sm_sel == MODE_PDOWN || q.sm_sel == MODE_STANDBY;

	// deep_sel looks at the programmed field, deep_now at the latched mode;
	// mixing them up would let a mode write during sleep move the detector.

	// Next state: registers, sleep sequence and derived enables
	always_comb
	begin
		d = q;
		deep_now = 1'b0;
		gate_run = 1'b0;

		// Register writes
		if (ctrl_wr)
		begin
			d.se     = reg_wdata_i[CTRL_SE_BIT];
			d.sm_sel = sleep_mode_t'(reg_wdata_i[CTRL_SM_HI:CTRL_SM_LO]);
		end
		if (gate_wr)
		begin
			d.gate = reg_wdata_i[GATE_W-1:0];
		end

		// Register reads, data valid only in the following cycle
		// Read data idles at zero between reads, so that several
		// slaves can share one read bus through a plain OR.
		d.rdata = RDATA_RST;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				GATE_ADDR:
				begin
					d.rdata[GATE_W-1:0] = q.gate;
				end
				CTRL_ADDR:
				begin
					d.rdata[CTRL_OFF_BIT]             = seq_bus.off_bit;
					d.rdata[CTRL_SE_BIT]              = q.se;
					d.rdata[CTRL_SM_HI:CTRL_SM_LO]    = q.sm_sel;
					d.rdata[CTRL_UNLOCK_BIT]          = seq_bus.unlock_bit;
				end
				default:
				begin
					d.rdata = RDATA_RST;
				end
			endcase
		end

		// Sleep state machine
		case (q.st)
			ST_RUN:
			begin
				if (sleep_instr_i && q.se)
				begin
					d.st      = ST_SLEEP;
					d.mode    = q.sm_sel;
					d.bod_off = seq_bus.effective && deep_sel;
				end
			end
			ST_SLEEP:
			begin
				if (wake_i)
				begin
					d.st      = ST_RUN;
					d.bod_off = 1'b0;
				end
			end
			default:
			begin
				d.st      = ST_RUN;
				d.bod_off = 1'b0;
			end
		endcase

		// Clock domains per mode
		// Enables come from the next state, so they change in the same
		// cycle as sleeping_o and never lag it by one cycle.
		d.cpu_en = d.st != ST_SLEEP;
		d.io_en  = d.st != ST_SLEEP || d.mode == MODE_IDLE;
		d.adc_en = d.st != ST_SLEEP || d.mode == MODE_IDLE || d.mode == MODE_NOISE;
		d.osc_en = d.st != ST_SLEEP || d.mode != MODE_PDOWN;
		deep_now = d.st == ST_SLEEP && (d.mode == MODE_PDOWN || d.mode == MODE_STANDBY);

		// Per-peripheral clock enables: stop bit frees or freezes each one
		for (int i = 0; i < GATE_W; i++)
		begin
			gate_run    = GATE_ON_ADC[i] ? d.adc_en : d.io_en;
			d.per_en[i] = gate_run && !d.gate[i];
		end

		// Serial block restart request when its stop bit falls
		d.ser_reinit = q.gate[GATE_SER_BIT] && !d.gate[GATE_SER_BIT];

		// Converter enable is untouched by sleep
		d.conv_en   = conv_en_i;
		d.conv_prev = conv_en_i;
		if (conv_start_i)
		begin
			d.conv_ext = 1'b0;
		end
		if (conv_en_i && !q.conv_prev)
		begin
			d.conv_ext = 1'b1;
		end

		// Comparator availability
		// A set converter stop bit removes the comparator in every mode;
		// the reference input only keeps it alive through deep sleep.
		d.comp_en = comp_en_i && !d.gate[GATE_CONV_BIT]
			&& (!deep_now || comp_uses_ref_i);

		// Input buffers: only wake pins stay on when io and adc clocks stop
		// Wake pins keep their buffers so a pin change can still end sleep;
		// the rest are cut to stop leakage from floating inputs.
		d.buf_en = (!d.io_en && !d.adc_en) ? wake_pin_mask_i : '1;

		// Brown-out detector and watchdog across sleep
		d.bod_en = bod_fuse_en_i && !(deep_now && d.bod_off);
		d.wdt_en = wdt_en_i;
	end

	// State register
	// Reset raises every clock enable so that the core runs at once;
	// the sleep-off latch and the status outputs start cleared.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			q            <= '0;
			q.st         <= ST_RUN;
			q.mode       <= MODE_IDLE;
			q.sm_sel     <= MODE_IDLE;
			q.gate       <= GATE_RST;
			q.rdata      <= RDATA_RST;
			q.cpu_en     <= 1'b1;
			q.io_en      <= 1'b1;
			q.adc_en     <= 1'b1;
			q.osc_en     <= 1'b1;
			q.per_en     <= '1;
			q.buf_en     <= '1;
		end
		else
		begin
			q <= d;
		end
	end

	// Outputs straight from the state
	// Enables leave through flip-flops only, so the gates outside see
	// no glitch when several fields change in one cycle.
	assign reg_rdata_o     = q.rdata;
	assign sleeping_o      = q.st == ST_SLEEP;
	assign sleep_mode_o    = q.mode;
	assign cpu_clk_en_o    = q.cpu_en;
	assign io_clk_en_o     = q.io_en;
	assign adc_clk_en_o    = q.adc_en;
	assign osc_en_o        = q.osc_en;
	assign timer1_clk_en_o = q.per_en[GATE_T1_BIT];
	assign timer0_clk_en_o = q.per_en[GATE_T0_BIT];
	assign serial_clk_en_o = q.per_en[GATE_SER_BIT];
	assign conv_clk_en_o   = q.per_en[GATE_CONV_BIT];
	assign serial_reinit_o = q.ser_reinit;
	assign conv_en_o       = q.conv_en;
	assign conv_extended_o = q.conv_ext;
	assign comp_en_o       = q.comp_en;
	assign in_buf_en_o     = q.buf_en;
	assign bod_en_o        = q.bod_en;
	assign wdt_en_o        = q.wdt_en;
endmodule // sleep_clock_ctrl
